//--- design/snooze_defs.svh
// What this block does
// [RULE1] Standby enters snooze on enabled transition condition
// [RULE2] End condition returns snooze to standby, clocks off
// [RULE3] No selected condition keeps standby despite events
// [RULE4] Software sets transfer enable and peripherals beforehand
// [RULE5] Channel five: off or receive pin falling edge
// [RULE6] Channel five end: mismatch, or mismatch or transfer
// [RULE7] Timer: off or match one; end none/transfer
// [RULE8] Converter: off or match one; end none/transfer
// [RULE9] Touch unit: off or match one; end request
// [RULE10] Listed interrupts and resets cancel snooze to normal
// [RULE11] Selected release source raises release irq, wakes
// [RULE12] Channel five release: none, error, full, transfer
// [RULE13] Timer release: none, match one, transfer end
// [RULE14] Converter release: none, conversion end, transfer end
// [RULE15] Touch release: none or measurement end
// [RULE16] Software clears transfer irq select for counts
// [RULE17] Release irq vector 81, edge, not transfer-activatable
// [RULE18] Software enables source and release interrupts first
// [RULE19] Selected source still raises its own interrupt
// [RULE20] Release irq also fires outside snooze mode
// [RULE21] Snooze clocks chosen peripherals, CPU stays stopped
// [RULE22] Event-linked peripherals lack end or release settings
// [RULE23] Peripheral clocks gated after oscillator stabilization
`ifndef SNOOZE_DEFS_SVH
`define SNOOZE_DEFS_SVH

`define ADR_CTRL 2'h0
`define ADR_REL 2'h1
`define ADR_STAT 2'h2
`define ADR_MODE 2'h3
// Control register fields
`define C_SER_TR 0
`define C_SER_END 1
`define C_LPT_TR 2
`define C_LPT_END 3
`define C_ADC_TR 4
`define C_ADC_END 5
`define C_TCH_TR 6
`define C_XFER_EN 7
// Release select register fields
`define R_SER_LO 0
`define R_SER_HI 1
`define R_LPT_LO 2
`define R_LPT_HI 3
`define R_ADC_LO 4
`define R_ADC_HI 5
`define R_TCH 6
`define REG_W 8
`define STAB_NS 2000
`define CLK_NS 20
`define STAB_CYC ((`STAB_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W 8
`define VECTOR_NUM 8'h51
`define SEL_NONE 2'h0
`define SEL_A 2'h1
`define SEL_B 2'h2
`define SEL_C 2'h3

`endif

//--- design/snooze_mode_controller.sv
`timescale 1ns/10ps
`include "snooze_defs.svh"

module snooze_mode_controller (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic standby_req_i,
    input wire snooze_pkg::periph_ev_t ev_i,
    input wire snooze_pkg::cancel_ev_t cancel_i,
    input wire logic osc_stable_i,
    output snooze_pkg::clk_ctl_t clk_o,
    output logic snooze_release_irq_o,
    output logic [7:0] release_vector_o,
    output logic release_xfer_ok_o,
    output snooze_pkg::mode_t mode_o
);

snooze_pkg::state_t s_r;
snooze_pkg::state_t s_nxt;
logic trans_hit;
logic end_hit;
logic rel_hit;
logic cancel_hit;
logic [1:0] ser_sel;
logic [1:0] lpt_sel;
logic [1:0] adc_sel;
logic in_snz;

////////////////////////////////////////////////////////////////////////
// Condition decode

always_comb begin
    ser_sel = s_r.rel[`R_SER_HI:`R_SER_LO];
    lpt_sel = s_r.rel[`R_LPT_HI:`R_LPT_LO];
    adc_sel = s_r.rel[`R_ADC_HI:`R_ADC_LO];
    // Unselected conditions are masked, so events alone never enter
    trans_hit = (s_r.ctrl[`C_SER_TR] & ev_i.rx_fall)          // [RULE5]
        | (s_r.ctrl[`C_LPT_TR] & ev_i.lpt_match)              // [RULE7]
        | (s_r.ctrl[`C_ADC_TR] & ev_i.lpt_match)              // [RULE8]
        | (s_r.ctrl[`C_TCH_TR] & ev_i.lpt_match);             // [RULE3] [RULE9]
    // Mismatch needs match detection enabled in the receiver
    end_hit = (s_r.ctrl[`C_SER_TR] & (ev_i.rx_mismatch
            | (s_r.ctrl[`C_SER_END] & ev_i.rx_xfer)))        // [RULE6]
        | (s_r.ctrl[`C_LPT_TR] & s_r.ctrl[`C_LPT_END]
            & ev_i.lpt_xfer)                                  // [RULE7]
        | (s_r.ctrl[`C_ADC_TR] & s_r.ctrl[`C_ADC_END]
            & ev_i.adc_xfer)                                  // [RULE8]
        | (s_r.ctrl[`C_TCH_TR] & ev_i.tch_end_req);           // [RULE9]
    rel_hit = 1'b0;
    unique case (ser_sel)                                     // [RULE12]
        `SEL_NONE: rel_hit = rel_hit;
        `SEL_A: rel_hit = rel_hit | ev_i.rx_err_irq;
        `SEL_B: rel_hit = rel_hit | ev_i.rx_full_irq;
        `SEL_C: rel_hit = rel_hit | ev_i.rx_xfer_end;
    endcase
    unique case (lpt_sel)                                     // [RULE13]
        `SEL_A: rel_hit = rel_hit | ev_i.lpt_match;
        `SEL_B: rel_hit = rel_hit | ev_i.lpt_xfer_end;
        default: rel_hit = rel_hit;
    endcase
    unique case (adc_sel)                                     // [RULE14]
        `SEL_A: rel_hit = rel_hit | ev_i.adc_end_irq;
        `SEL_B: rel_hit = rel_hit | ev_i.adc_xfer_end;
        default: rel_hit = rel_hit;
    endcase
    rel_hit = rel_hit | (s_r.rel[`R_TCH] & ev_i.tch_meas_irq); // [RULE15]
    // Source interrupts are only watched, never swallowed, so the
    // selected peripheral still raises its own request after wake-up
    // [RULE19]
    cancel_hit = |cancel_i;                                   // [RULE10]
end

////////////////////////////////////////////////////////////////////////
// Mode sequence and register slave

always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    // Release interrupt is a registered copy of the rel_hit level in every mode
    s_nxt.irq = rel_hit;                                      // [RULE11] [RULE20]
    unique case (s_r.mode)
        snooze_pkg::MODE_NORMAL: begin
            if (standby_req_i && !cancel_hit) begin
                s_nxt.mode = snooze_pkg::MODE_STANDBY;
            end
        end
        snooze_pkg::MODE_STANDBY: begin
            if (cancel_hit) begin
                s_nxt.mode = snooze_pkg::MODE_NORMAL;
            end else if (trans_hit) begin
                s_nxt.mode = snooze_pkg::MODE_STAB;           // [RULE1]
                s_nxt.cnt = '0;
            end
        end
        snooze_pkg::MODE_STAB: begin
            if (cancel_hit) begin
                s_nxt.mode = snooze_pkg::MODE_NORMAL;
            end else if (osc_stable_i
                    && s_r.cnt >= 8'(`STAB_CYC - 1)) begin
                s_nxt.mode = snooze_pkg::MODE_SNOOZE;         // [RULE23]
            end else if (s_r.cnt < 8'(`STAB_CYC - 1)) begin
                s_nxt.cnt = s_r.cnt + 8'h01;
            end
        end
        snooze_pkg::MODE_SNOOZE: begin
            if (cancel_hit || rel_hit) begin
                s_nxt.mode = snooze_pkg::MODE_NORMAL;         // [RULE10] [RULE11]
            end else if (end_hit) begin
                s_nxt.mode = snooze_pkg::MODE_STANDBY;        // [RULE2]
            end
        end
    endcase
    if (cyc_i && stb_i && !s_r.ack) begin
        s_nxt.ack = 1'b1;
        s_nxt.dat = '0;
        unique case (adr_i[3:2])
            `ADR_CTRL: begin
                s_nxt.dat[7:0] = s_r.ctrl;
                if (we_i && sel_i[0]) begin
                    s_nxt.ctrl = dat_i[7:0];
                end
            end
            `ADR_REL: begin
                s_nxt.dat[7:0] = s_r.rel;
                if (we_i && sel_i[0]) begin
                    s_nxt.rel = {1'b0, dat_i[6:0]};
                end
            end
            `ADR_STAT: s_nxt.dat[7:0] = {6'h00, s_r.mode};
            `ADR_MODE: s_nxt.dat[7:0] = `VECTOR_NUM;
        endcase
    end
end

always_ff @(posedge clk_i) begin
    if (rst_i) begin
        s_r <= '0;
    end else begin
        s_r <= s_nxt;
    end
end

////////////////////////////////////////////////////////////////////////
// Outputs

assign in_snz = (s_r.mode == snooze_pkg::MODE_SNOOZE);
assign dat_o = s_r.dat;
assign ack_o = s_r.ack;
assign mode_o = s_r.mode;
assign snooze_release_irq_o = s_r.irq;                       // [RULE17]
assign release_vector_o = `VECTOR_NUM;                       // [RULE17]
// The release interrupt never starts a transfer
assign release_xfer_ok_o = 1'b0;                             // [RULE17]

// Event-linked units only get clocks; they have no end or release
// selection, so another cancel source must wake the CPU [RULE22]
always_comb begin
    clk_o.osc_run = (s_r.mode != snooze_pkg::MODE_STANDBY);  // [RULE2]
    clk_o.cpu_run = (s_r.mode == snooze_pkg::MODE_NORMAL);   // [RULE21]
    clk_o.ser_clk = clk_o.cpu_run | (in_snz & s_r.ctrl[`C_SER_TR]);
    clk_o.lpt_clk = clk_o.cpu_run | (in_snz & s_r.ctrl[`C_LPT_TR]);
    clk_o.adc_clk = clk_o.cpu_run | (in_snz & s_r.ctrl[`C_ADC_TR]);
    clk_o.tch_clk = clk_o.cpu_run | (in_snz & s_r.ctrl[`C_TCH_TR]);
    clk_o.xfer_clk = clk_o.cpu_run
        | (in_snz & s_r.ctrl[`C_XFER_EN]);                  // [RULE21]
end

endmodule

//--- design/snooze_pkg.sv
package snooze_pkg;

typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_STANDBY = 2'b01,
    MODE_STAB = 2'b10,
    MODE_SNOOZE = 2'b11
} mode_t;

// Peripheral events seen by the controller
typedef struct packed {
    logic rx_fall;
    logic rx_mismatch;
    logic rx_xfer;
    logic rx_err_irq;
    logic rx_full_irq;
    logic rx_xfer_end;
    logic lpt_match;
    logic lpt_xfer;
    logic lpt_xfer_end;
    logic adc_end_irq;
    logic adc_xfer;
    logic adc_xfer_end;
    logic tch_end_req;
    logic tch_meas_irq;
} periph_ev_t;

// Wake sources outside the release interrupt
typedef struct packed {
    logic nmi;
    logic ext_irq;
    logic rtc_alarm;
    logic rtc_period;
    logic wdt_irq;
    logic volt_irq;
    logic any_reset;
} cancel_ev_t;

typedef struct packed {
    logic osc_run;
    logic cpu_run;
    logic ser_clk;
    logic lpt_clk;
    logic adc_clk;
    logic tch_clk;
    logic xfer_clk;
} clk_ctl_t;

typedef struct packed {
    mode_t mode;
    logic [7:0] ctrl;
    logic [7:0] rel;
    logic [7:0] cnt;
    logic irq;
    logic ack;
    logic [31:0] dat;
} state_t;

endpackage

//--- sim/snooze_mode_controller_properties.sv
`timescale 1ns/10ps
module snooze_mode_controller_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire snooze_pkg::cancel_ev_t cancel_i,
    input wire logic osc_stable_i,
    input wire snooze_pkg::clk_ctl_t clk_o,
    input wire logic snooze_release_irq_o,
    input wire logic [7:0] release_vector_o,
    input wire logic release_xfer_ok_o,
    input wire snooze_pkg::mode_t mode_o
);
    localparam snooze_pkg::mode_t NRM = snooze_pkg::MODE_NORMAL;
    localparam snooze_pkg::mode_t SBY = snooze_pkg::MODE_STANDBY;
    localparam snooze_pkg::mode_t STB = snooze_pkg::MODE_STAB;
    localparam snooze_pkg::mode_t SNZ = snooze_pkg::MODE_SNOOZE;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] stab_r;
    always_ff @(posedge clk_i) begin
        stab_r <= (mode_o == STB) ? stab_r + 8'h1 : 8'h0;
    end
    ack_once_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
    ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack late");
    vector_fix_a: assert property (release_vector_o == 8'h51 &&
        !release_xfer_ok_o) else $error("vector wrong");
    stab_from_a: assert property (mode_o == STB && $past(mode_o) != STB
        |-> $past(mode_o) == SBY) else $error("bad stab entry");
    stab_wait_a: assert property (mode_o == SNZ && $past(mode_o) == STB
        |-> stab_r >= 8'd99 && $past(osc_stable_i)) else $error("early");
    cancel_wake_a: assert property (|cancel_i && mode_o != NRM
        |=> mode_o == NRM) else $error("cancel ignored");
    stby_clk_a: assert property (mode_o == SBY |-> clk_o == '0)
        else $error("clocks in standby");
    snz_clk_a: assert property (mode_o == SNZ
        |-> clk_o.osc_run && !clk_o.cpu_run) else $error("snooze clocks");
    stab_clk_a: assert property (mode_o == STB
        |-> clk_o.osc_run && clk_o[4:0] == 5'h0) else $error("stab clocks");
    irq_wake_a: assert property (snooze_release_irq_o && $past(mode_o) == SNZ
        |-> mode_o == NRM) else $error("irq no wake");
    cover property (mode_o == STB ##1 mode_o == SNZ);
    cover property (mode_o == SNZ ##1 mode_o == SBY);
    cover property (snooze_release_irq_o && mode_o == NRM);
endmodule
bind snooze_mode_controller snooze_mode_controller_properties chk (.*);

//--- sim/snooze_mode_controller_tb.sv
`timescale 1ns/10ps
module snooze_mode_controller_tb;
    logic clk_i, rst_i, cyc, stb, we, sreq, go, ack_o, irq, osc;
    logic [3:0] adr, sel, idx;
    logic [31:0] dat, dat_o, expq[$];
    logic [15:0] lf = 16'had41;
    logic [23:0] tt[7] = '{24'h01dc31, 24'h03db31, 24'h0c7631, 24'h047633,
        24'h307331, 24'h407131, 24'h00d011};
    logic [11:0] rt[8] = '{12'h01a, 12'h029, 12'h038, 12'h047, 12'h085,
        12'h104, 12'h202, 12'h400};
    int err_total, comparisons, irqs, cycles, n;
    snooze_pkg::periph_ev_t ev;
    snooze_pkg::cancel_ev_t cn;
    snooze_pkg::clk_ctl_t ck;
    snooze_pkg::mode_t md;
    snooze_mode_controller DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
        .dat_o(dat_o), .ack_o(ack_o), .standby_req_i(sreq), .ev_i(ev),
        .cancel_i(cn), .osc_stable_i(osc), .clk_o(ck),
        .snooze_release_irq_o(irq), .release_vector_o(),
        .release_xfer_ok_o(), .mode_o(md));
    snooze_periph_model far (.clk_i(clk_i), .osc_run_i(ck.osc_run),
        .go_i(go), .idx_i(idx), .ev_o(ev), .osc_stable_o(osc));
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic bus(input logic w, input int a, input logic [31:0] d,
        input logic [3:0] s);
        cyc <= 1; stb <= 1; we <= w; adr <= {a[1:0], 2'b00}; dat <= d; sel <= s;
        tick(1);
        while (ack_o !== 1'b1) tick(1);
        cyc <= 0;
        stb <= 0;
        tick(1);
    endtask
    task automatic rd(input int a, input logic [31:0] e);
        expq.push_back(e);
        bus(0, a, 0, 4'hf);
    endtask
    task automatic fire(input logic [3:0] i);
        idx <= i; go <= 1; tick(1);
        go <= 0; tick(2);
    endtask
    task automatic cncl;
        cn <= snooze_pkg::cancel_ev_t'(7'h1 << (lf % 7)); lf = nx(lf); tick(1);
        cn <= '0; tick(2);
    endtask
    task automatic end_sim;
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        clk_i = 0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we === 1'b0) chk("rdata", expq.pop_front(), dat_o);
        if (irq === 1'b1) irqs++;
        if (++cycles > 20000) begin
            err_total++;
            end_sim;
        end
    end
    initial begin
        {cyc, stb, we, sreq, go, adr, sel, idx, dat, cn} = '0;
        rst_i = 1;
        tick(20);
        rst_i <= 0;
        tick(1);
        rd(0, 0); rd(1, 0); rd(2, 0);
        bus(1, 3, 0, 4'hf); rd(3, 32'h51);
        bus(1, 0, 32'hff, 4'he); rd(0, 0);
        bus(1, 0, {16'h0, lf}, 4'hf); rd(0, {24'h0, lf[7:0]});
        foreach (tt[i]) begin
            bus(1, 0, {24'h0, tt[i][23:16]}, 4'hf);
            sreq <= 1; tick(1); sreq <= 0; tick(1);
            fire(tt[i][15:12]); tick(160);
            rd(2, tt[i][7:4]);
            fire(tt[i][11:8]);
            rd(2, tt[i][3:0]);
            cncl; rd(2, 0);
        end
        foreach (rt[i]) begin
            bus(1, 1, {24'h0, rt[i][11:4]}, 4'hf);
            bus(1, 0, 32'h1, 4'hf); n = irqs;
            sreq <= 1; tick(1); sreq <= 0; tick(1);
            fire(4'hd); tick(160); rd(2, 3);
            fire(rt[i][3:0]); rd(2, 0);
            chk("irq", n + 1, irqs);
            fire(rt[i][3:0]); tick(1); chk("irq", n + 2, irqs);
        end
        sreq <= 1; tick(1); sreq <= 0; tick(2);
        rst_i <= 1; tick(2); rst_i <= 0; tick(1);
        rd(0, 0); rd(2, 0);
        end_sim;
    end
endmodule

//--- sim/snooze_periph_model.sv
`timescale 1ns/10ps
module snooze_periph_model #(parameter int OSC_DLY = 30) (
    input wire logic clk_i,
    input wire logic osc_run_i,
    input wire logic go_i,
    input wire logic [3:0] idx_i,
    output snooze_pkg::periph_ev_t ev_o = '0,
    output logic osc_stable_o = 1'b0
);
    logic [7:0] cnt_r = 8'h0;
    // Events are one-cycle pulses; oscillator settles only while running
    always_ff @(posedge clk_i) begin
        ev_o <= '0;
        if (go_i) ev_o[idx_i] <= 1'b1;
        cnt_r <= !osc_run_i ? 8'h0 : cnt_r + 8'(cnt_r != 8'(OSC_DLY));
        osc_stable_o <= osc_run_i && cnt_r == 8'(OSC_DLY);
    end
endmodule
